/* File: nic_cpu_model.sv */
`timescale 1ns/1ps
module nic_cpu_model (
  input wire logic clock,
  input wire logic resetn,
  input wire logic run,
  input wire logic [3:0] lag,
  input wire logic stackReq,
  output logic instrEnd,
  output logic stackDone
);
  logic [3:0] lagCnt;
  logic [1:0] phase;

  // ---------------------------------------------------------------
  // instruction boundaries and context push
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      lagCnt <= 4'h0;
      phase <= 2'h0;
      instrEnd <= 1'h0;
      stackDone <= 1'h0;
    end else begin
      phase <= phase + 2'h1;
      instrEnd <= run && !stackReq && phase == 2'h3;
      if (stackReq && !stackDone) begin
        if (lagCnt >= lag) begin
          stackDone <= 1'h1;
        end else begin
          lagCnt <= lagCnt + 4'h1;
        end
      end else begin
        lagCnt <= 4'h0;
        stackDone <= 1'h0;
      end
    end
  end
endmodule

/* File: nic_ctrl.sv */
// What this block does
// - at instruction end, stack PC, X, A and condition code before entering a routine.
// - maskable entry loads the condition code priority bits from that vector's stored pair.
// - current priority lives in condition code bit 5 (high) and bit 3 (low).
// - after stacking, PC loads from fixed slots FFE0h-FFFFh, hardware ordered.
// - return pops saved registers, restoring the former priority bits.
// - pairs 10,01,00,11 mean levels 0,1,2,3; level 3 masks.
// - highest software level wins; ties go to fixed hardware order.
// - unserviced requests stay latched until they win.
// - top pin, reset and trap count as highest software priority.
// - reset and trap ignore the mask, stack (not reset), load level 3.
// - reset and trap can end HALT.
// - trap instruction raises trap; top pin may preempt its routine.
// - reset is highest; code after reset runs at level 3.
// - maskable served only if enabled and strictly above current level.
// - selected edge on top pin raises top interrupt, served like a trap but vectored to a qualifying maskable winner's slot instead of FFFAh.
// - edge external request latched, cleared on routine entry.
// - selected pins sharing a line are ORed.
// - external lines wake HALT; sensitivity chosen by software.
// - peripheral request is its flag and its enable.
// - peripheral clearing sequence resets the latch, discarding pending request.
// - any interrupt ends WAIT; only HALT-capable sources end HALT.
// - first request after HALT is HALT-capable; others follow after.
`timescale 1ns/1ps
module nic_ctrl
  import nic_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRData,
  input wire logic topLevelIrq,
  input wire logic [15:0] extPins,
  input wire logic [8:0] periphFlag,
  input wire logic [8:0] periphEn,
  input wire logic [8:0] periphClr,
  input wire logic instrEnd,
  input wire logic trapExec,
  input wire logic returnFromIsr,
  input wire logic [7:0] popCond,
  input wire logic enterWait,
  input wire logic enterHalt,
  input wire logic stackDone,
  output logic stackReq,
  output logic vectorLoad,
  output logic [15:0] vectorAddr,
  output logic [7:0] condCodeReg,
  output logic lowPower,
  output logic haltMode,
  output logic wakeUp
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    nic_state_e state;
    logic [31:0] vectorPriorityRegs;
    logic [7:0] condCodeReg;
    logic [7:0] extIrqSenseCtrl;
    logic [15:0] extSel;
    logic topRise;
    logic topPrev;
    logic topReq;
    logic trapPend;
    nic_kind_e svcKind;
    logic [3:0] svcIdx;
    logic [3:0] extAck;
    logic [7:0] rdata;
    logic stackReq;
    logic vectorLoad;
    logic [15:0] vectorAddr;
    logic lowPower;
    logic haltMode;
    logic haltExit;
    logic wakeUp;
  } nic_ctrl_s;

  nic_ctrl_s r, next_r;
  logic [13:0] req;
  logic [3:0] extReq;
  logic [8:0] perReq;

  // ---------------------------------------------------------------
  // source latches
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_EXT; g++) begin : gExt
      nic_ext_line uLine (
        .clock(clock),
        .resetn(resetn),
        // selected pins ORed onto the line
        .lineLevel(|(extPins[4*g +: 4] & r.extSel[4*g +: 4])),
        .sense(r.extIrqSenseCtrl[2*g +: 2]),
        .ack(r.extAck[g]),
        .req(extReq[g])
      );
    end
    for (g = 0; g < NUM_PERIPH; g++) begin : gPer
      nic_periph_line uLine (
        .clock(clock),
        .resetn(resetn),
        .flag(periphFlag[g]),
        .enable(periphEn[g]),
        .clearSeq(periphClr[g]),
        .req(perReq[g])
      );
    end
  endgenerate

  assign req = {perReq[8:1], extReq, perReq[0], r.topReq};

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic [1:0] curLvl;
  logic [1:0] lvlI;
  logic [1:0] bestLvl;
  logic found;
  logic [3:0] winIdx;
  nic_kind_e winKind;
  logic tliEdge;
  logic wakeNow;
  logic [1:0] oldPair;
  logic [1:0] newPair;

  always_comb begin
    next_r = r;
    curLvl = nic_level({r.condCodeReg[COND_PRIO_HI], r.condCodeReg[COND_PRIO_LO]});
    lvlI = 2'd0;
    bestLvl = 2'd0;
    found = 1'b0;
    winIdx = 4'd0;
    winKind = K_NONE;
    wakeNow = 1'b0;
    oldPair = 2'b00;
    newPair = 2'b00;
    next_r.vectorLoad = 1'b0;
    next_r.wakeUp = 1'b0;
    next_r.extAck = 4'h0;
    next_r.rdata = 8'h00;

    // selected edge on the top pin
    next_r.topPrev = topLevelIrq;
    tliEdge = r.topRise ? (topLevelIrq && !r.topPrev) : (!topLevelIrq && r.topPrev);
    next_r.trapPend = r.trapPend || trapExec;
    next_r.topReq = r.topReq || tliEdge;

    // scan from low hardware priority, lower index wins ties
    for (int i = NUM_VEC - 1; i >= 1; i--) begin
      lvlI = nic_level(r.vectorPriorityRegs[2*i +: 2]);
      // strictly above current level, halt-capable first
      if (req[i] && lvlI > curLvl && (!r.haltExit || HALT_CAP[i]) &&
          (!found || lvlI >= bestLvl)) begin
        found = 1'b1;
        bestLvl = lvlI;
        winIdx = 4'(i);
      end
    end
    // trap and top pin beat every maskable source
    if (r.trapPend) begin
      winKind = K_TRAP;
    end else if (r.topReq) begin
      winKind = K_TOP;
    end else if (found) begin
      winKind = K_MASK;
    end

    // wake from wait on any, from halt on capable only
    // trap and external lines end halt
    wakeNow = r.trapPend || (r.haltMode ? |(req & HALT_CAP) : |req);
    if (r.lowPower && wakeNow) begin
      next_r.lowPower = 1'b0;
      next_r.wakeUp = 1'b1;
      next_r.haltExit = r.haltMode;
      next_r.haltMode = 1'b0;
    end

    case (r.state)
      ST_RESET: begin
        // reset vector at level 3, no stacking
        next_r.vectorLoad = 1'b1;
        next_r.vectorAddr = VEC_RESET;
        next_r.condCodeReg[COND_PRIO_HI] = PRIO_L3[1];
        next_r.condCodeReg[COND_PRIO_LO] = PRIO_L3[0];
        next_r.state = ST_RUN;
      end
      ST_RUN: begin
        if (instrEnd && !r.lowPower && winKind != K_NONE) begin
          next_r.state = ST_STACK;
          next_r.stackReq = 1'b1;
          next_r.svcKind = winKind;
          next_r.svcIdx = winIdx;
          if (winKind == K_TRAP) begin
            next_r.trapPend = trapExec;
          end else if (winKind == K_TOP) begin
            next_r.topReq = tliEdge;
          end else if (winIdx >= 4'(EXT_BASE) && winIdx < 4'(EXT_BASE + NUM_EXT)) begin
            // clear external edge latch on entry
            next_r.extAck[2'(winIdx - 4'(EXT_BASE))] = 1'b1;
          end
        end
      end
      ST_STACK: begin
        // vector only after context is stacked
        if (stackDone) begin
          next_r.stackReq = 1'b0;
          next_r.vectorLoad = 1'b1;
          next_r.haltExit = 1'b0;
          next_r.state = ST_RUN;
          if (r.svcKind == K_TRAP) begin
            next_r.vectorAddr = VEC_TRAP;
          end else begin
            next_r.vectorAddr = VEC_TOP - {11'h000, r.svcIdx, 1'b0};
          end
          // load stored pair; trap and top pin load level 3
          if (r.svcKind == K_MASK) begin
            next_r.condCodeReg[COND_PRIO_HI] = r.vectorPriorityRegs[2*r.svcIdx + 1];
            next_r.condCodeReg[COND_PRIO_LO] = r.vectorPriorityRegs[2*r.svcIdx];
          end else begin
            next_r.condCodeReg[COND_PRIO_HI] = PRIO_L3[1];
            next_r.condCodeReg[COND_PRIO_LO] = PRIO_L3[0];
          end
        end
      end
      default: begin
        next_r.state = ST_RUN;
      end
    endcase

    // low-power entry drops to level 0
    if (enterHalt || enterWait) begin
      next_r.lowPower = 1'b1;
      next_r.haltMode = enterHalt;
      next_r.condCodeReg[COND_PRIO_HI] = PRIO_L0[1];
      next_r.condCodeReg[COND_PRIO_LO] = PRIO_L0[0];
    end

    // register writes
    if (regWr) begin
      case (regAddr)
        ADDR_PRIO0, ADDR_PRIO1, ADDR_PRIO2, ADDR_PRIO3: begin
          for (int p = 0; p < 4; p++) begin
            oldPair = r.vectorPriorityRegs[8*regAddr[1:0] + 2*p +: 2];
            newPair = regWData[2*p +: 2];
            // level 0 pair is not writable
            if (newPair == PRIO_L0) begin
              newPair = oldPair;
            end
            if (regAddr == ADDR_PRIO3 && p >= 2) begin
              newPair = 2'b11;
            end
            next_r.vectorPriorityRegs[8*regAddr[1:0] + 2*p +: 2] = newPair;
          end
        end
        ADDR_COND: next_r.condCodeReg = regWData;
        ADDR_SENSE: next_r.extIrqSenseCtrl = regWData;
        ADDR_SEL_LO: next_r.extSel[7:0] = regWData;
        ADDR_SEL_HI: next_r.extSel[15:8] = regWData;
        ADDR_TOP_CTL: next_r.topRise = regWData[0];
        default: begin
        end
      endcase
    end

    // return restores the stacked CC, priority bits included
    if (returnFromIsr) begin
      next_r.condCodeReg = popCond;
    end

    // register reads, data valid one cycle later
    if (regRd) begin
      case (regAddr)
        ADDR_PRIO0: next_r.rdata = r.vectorPriorityRegs[7:0];
        ADDR_PRIO1: next_r.rdata = r.vectorPriorityRegs[15:8];
        ADDR_PRIO2: next_r.rdata = r.vectorPriorityRegs[23:16];
        ADDR_PRIO3: next_r.rdata = r.vectorPriorityRegs[31:24] | PRIO3_RO_MASK;
        ADDR_COND: next_r.rdata = r.condCodeReg;
        ADDR_SENSE: next_r.rdata = r.extIrqSenseCtrl;
        ADDR_SEL_LO: next_r.rdata = r.extSel[7:0];
        ADDR_SEL_HI: next_r.rdata = r.extSel[15:8];
        ADDR_TOP_CTL: next_r.rdata = {7'h00, r.topRise};
        ADDR_PEND_LO: next_r.rdata = req[7:0];
        ADDR_PEND_HI: next_r.rdata = {r.trapPend, 1'b0, req[13:8]};
        ADDR_MODE: next_r.rdata = {3'h0, r.stackReq, r.haltExit, r.haltMode, r.lowPower,
                                   r.state == ST_RUN};
        default: next_r.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      r <= '0;
      r.state <= ST_RESET;
      r.vectorPriorityRegs <= RST_PRIO;
      r.condCodeReg <= RST_COND;
      r.extIrqSenseCtrl <= RST_SENSE;
      r.extSel <= RST_SEL;
      r.topRise <= RST_TOP_RISE;
      r.svcKind <= K_NONE;
    end else begin
      r <= next_r;
    end
  end

  assign regRData = r.rdata;
  assign stackReq = r.stackReq;
  assign vectorLoad = r.vectorLoad;
  assign vectorAddr = r.vectorAddr;
  assign condCodeReg = r.condCodeReg;
  assign lowPower = r.lowPower;
  assign haltMode = r.haltMode;
  assign wakeUp = r.wakeUp;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  stack_then_vector_a: assert property (
    stackReq && stackDone |=> vectorLoad && !stackReq)
    else $error("vector not loaded after stacking");

  prio_load_a: assert property (
    stackReq && stackDone && r.svcKind == K_MASK && !returnFromIsr && !regWr
      && !enterHalt && !enterWait
    |=> {condCodeReg[5], condCodeReg[3]} == $past(r.vectorPriorityRegs[2*r.svcIdx +: 2]))
    else $error("priority bits not loaded from vector pair");

  trap_level3_a: assert property (
    vectorLoad && (vectorAddr == VEC_TRAP || vectorAddr == VEC_TOP)
    |-> $past(returnFromIsr) || (condCodeReg[5] && condCodeReg[3]))
    else $error("trap or top pin entry not at level 3");

  vector_slot_a: assert property (
    vectorLoad |-> vectorAddr >= VEC_FLOOR && !vectorAddr[0])
    else $error("vector outside slot area");

  return_restore_a: assert property (
    returnFromIsr |=> condCodeReg == $past(popCond))
    else $error("return did not restore cc");

  reset_entry_a: assert property (
    $rose(resetn) |=> vectorLoad && vectorAddr == VEC_RESET && condCodeReg[5] && condCodeReg[3])
    else $error("reset entry wrong");

  mask_above_a: assert property (
    $rose(stackReq) && r.svcKind == K_MASK
    |-> nic_level(r.vectorPriorityRegs[2*r.svcIdx +: 2]) >
        nic_level({$past(condCodeReg[5]), $past(condCodeReg[3])}))
    else $error("maskable taken at or below current level");

  halt_hold_a: assert property (
    lowPower && haltMode && !(|(req & HALT_CAP)) && !enterHalt && !enterWait |=> lowPower)
    else $error("halt left without capable source");

  halt_first_a: assert property (
    $rose(stackReq) && $past(r.haltExit) && r.svcKind == K_MASK |-> HALT_CAP[r.svcIdx])
    else $error("first request after halt not halt capable");

  trap_first_a: assert property (
    $rose(stackReq) && $past(r.trapPend) |-> r.svcKind == K_TRAP)
    else $error("trap lost arbitration");

  cover_trap_c: cover property (vectorLoad && vectorAddr == VEC_TRAP);
  cover_mask_c: cover property ($rose(stackReq) && r.svcKind == K_MASK);
  cover_halt_c: cover property (wakeUp && $past(haltMode));
  cover_return_c: cover property (returnFromIsr ##1 $rose(stackReq));

endmodule

/* File: nic_ext_line.sv */
`timescale 1ns/1ps
module nic_ext_line
  import nic_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic lineLevel,
  input wire logic [1:0] sense,
  input wire logic ack,
  output logic req
);

  typedef struct packed {
    logic prev;
    logic req;
  } nic_ext_s;

  nic_ext_s r, next_r;
  logic edgeSeen;

  always_comb begin
    next_r = r;
    next_r.prev = lineLevel;
    case (sense)
      SENSE_FALL: edgeSeen = r.prev && !lineLevel;
      SENSE_RISE: edgeSeen = !r.prev && lineLevel;
      SENSE_BOTH: edgeSeen = r.prev != lineLevel;
      default: edgeSeen = 1'b0;
    endcase
    if (sense == SENSE_LOW) begin
      next_r.req = !lineLevel;
    end else begin
      next_r.req = edgeSeen || (r.req && !ack);
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign req = r.req;

endmodule

/* File: nic_periph_line.sv */
`timescale 1ns/1ps
module nic_periph_line
  import nic_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic flag,
  input wire logic enable,
  input wire logic clearSeq,
  output logic req
);

  typedef struct packed {
    logic req;
  } nic_per_s;

  nic_per_s r, next_r;

  always_comb begin
    next_r = r;
    // clearing sequence drops a pending request
    if (clearSeq) begin
      next_r.req = 1'b0;
    // flag with its enable raises request
    end else if (flag && enable) begin
      next_r.req = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign req = r.req;

endmodule

/* File: nic_pkg.sv */
package nic_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PRIO0 = 8'h00;
  localparam logic [7:0] ADDR_PRIO1 = 8'h01;
  localparam logic [7:0] ADDR_PRIO2 = 8'h02;
  localparam logic [7:0] ADDR_PRIO3 = 8'h03;
  localparam logic [7:0] ADDR_COND = 8'h04;
  localparam logic [7:0] ADDR_SENSE = 8'h05;
  localparam logic [7:0] ADDR_SEL_LO = 8'h06;
  localparam logic [7:0] ADDR_SEL_HI = 8'h07;
  localparam logic [7:0] ADDR_TOP_CTL = 8'h08;
  localparam logic [7:0] ADDR_PEND_LO = 8'h09;
  localparam logic [7:0] ADDR_PEND_HI = 8'h0a;
  localparam logic [7:0] ADDR_MODE = 8'h0b;

  // ---------------------------------------------------------------
  // reset values and fields
  // ---------------------------------------------------------------
  localparam logic [31:0] RST_PRIO = 32'hffffffff;
  localparam logic [7:0] RST_COND = 8'hea;
  localparam logic [7:0] RST_SENSE = 8'h00;
  localparam logic [15:0] RST_SEL = 16'h0000;
  localparam logic RST_TOP_RISE = 1'b0;
  localparam logic [7:0] PRIO3_RO_MASK = 8'hf0;
  localparam int COND_PRIO_HI = 5;
  localparam int COND_PRIO_LO = 3;
  localparam logic [1:0] PRIO_L0 = 2'b10;
  localparam logic [1:0] PRIO_L3 = 2'b11;

  // ---------------------------------------------------------------
  // sources and vectors
  // ---------------------------------------------------------------
  localparam int NUM_VEC = 14;
  localparam int NUM_EXT = 4;
  localparam int EXT_BASE = 2;
  localparam int NUM_PERIPH = 9;
  localparam logic [13:0] HALT_CAP = 14'h00ff;
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_TRAP = 16'hfffc;
  localparam logic [15:0] VEC_TOP = 16'hfffa;
  localparam logic [15:0] VEC_FLOOR = 16'hffe0;

  localparam logic [1:0] SENSE_FALL = 2'b00;
  localparam logic [1:0] SENSE_RISE = 2'b01;
  localparam logic [1:0] SENSE_BOTH = 2'b10;
  localparam logic [1:0] SENSE_LOW = 2'b11;

  typedef enum logic [1:0] {ST_RESET, ST_RUN, ST_STACK} nic_state_e;
  typedef enum logic [1:0] {K_NONE, K_TRAP, K_TOP, K_MASK} nic_kind_e;

  // {hi,lo} pair to ordinal level 0..3
  function automatic logic [1:0] nic_level(input logic [1:0] pair);
    case (pair)
      2'b10: nic_level = 2'd0;
      2'b01: nic_level = 2'd1;
      2'b00: nic_level = 2'd2;
      default: nic_level = 2'd3;
    endcase
  endfunction

endpackage

/* File: tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin \
  checks++; \
  if ((a) !== (b)) begin \
    errCount++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); \
  end \
end

module tb
  import nic_pkg::*;
;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  logic clock, resetn, regWr, regRd, topLevelIrq, instrEnd, trapExec, returnFromIsr;
  logic enterWait, enterHalt, stackDone, stackReq, vectorLoad, lowPower, haltMode, wakeUp;
  logic run;
  logic [3:0] lag;
  logic [7:0] regAddr, regWData, regRData, popCond, condCodeReg;
  logic [15:0] extPins, vectorAddr;
  logic [8:0] periphFlag, periphEn, periphClr;
  int checks = 0;
  int errCount = 0;

  nic_ctrl dut (
    .clock(clock),
    .resetn(resetn),
    .regAddr(regAddr),
    .regWData(regWData),
    .regWr(regWr),
    .regRd(regRd),
    .regRData(regRData),
    .topLevelIrq(topLevelIrq),
    .extPins(extPins),
    .periphFlag(periphFlag),
    .periphEn(periphEn),
    .periphClr(periphClr),
    .instrEnd(instrEnd),
    .trapExec(trapExec),
    .returnFromIsr(returnFromIsr),
    .popCond(popCond),
    .enterWait(enterWait),
    .enterHalt(enterHalt),
    .stackDone(stackDone),
    .stackReq(stackReq),
    .vectorLoad(vectorLoad),
    .vectorAddr(vectorAddr),
    .condCodeReg(condCodeReg),
    .lowPower(lowPower),
    .haltMode(haltMode),
    .wakeUp(wakeUp)
  );

  nic_cpu_model cpu (
    .clock(clock),
    .resetn(resetn),
    .run(run),
    .lag(lag),
    .stackReq(stackReq),
    .instrEnd(instrEnd),
    .stackDone(stackDone)
  );

  initial begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end

  initial begin
    #500000;
    errCount++;
    completeRun();
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic completeRun();
    $display("checks %0d mismatches %0d", checks, errCount);
    if (errCount == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWData <= d;
    regWr <= 1'h1;
    @(posedge clock);
    regWr <= 1'h0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge clock);
    regRd <= 1'h0;
    #1;
    `CHK(regRData, e)
  endtask

  task automatic entry(input logic [15:0] a, input logic [1:0] p);
    int n;
    logic s;
    n = 0;
    s = 1'h0;
    do begin
      @(posedge clock);
      #1;
      s |= (stackReq === 1'h1);
      n++;
    end while (vectorLoad !== 1'h1 && n < 300);
    `CHK(vectorLoad, 1'h1)
    `CHK(s, 1'h1)
    `CHK(vectorAddr, a)
    `CHK({condCodeReg[5], condCodeReg[3]}, p)
  endtask

  task automatic waitw();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (wakeUp !== 1'h1 && n < 100);
    `CHK(wakeUp, 1'h1)
  endtask

  task automatic ret(input logic [7:0] p);
    @(posedge clock);
    returnFromIsr <= 1'h1;
    popCond <= p;
    @(posedge clock);
    returnFromIsr <= 1'h0;
    #1;
    `CHK(condCodeReg, p)
  endtask

  task automatic clr(input int j);
    @(posedge clock);
    periphFlag[j] <= 1'h0;
    periphClr[j] <= 1'h1;
    @(posedge clock);
    periphClr[j] <= 1'h0;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    rchk(ADDR_PRIO0, 8'hff);
    rchk(ADDR_COND, 8'hea);
    rchk(ADDR_MODE, 8'h01);
    rchk(8'h3c, 8'h00);
    wr(ADDR_PRIO0, 8'hcf);
    wr(ADDR_PRIO0, 8'h64);
    rchk(ADDR_PRIO0, 8'h44);
    wr(ADDR_PRIO3, 8'h00);
    rchk(ADDR_PRIO3, 8'hf0);
    $display("regs done");
  endtask

  task automatic t_periph();
    @(posedge clock);
    periphFlag[0] <= 1'h1;
    rchk(ADDR_PEND_LO, 8'h00);
    @(posedge clock);
    periphEn <= 9'h1ff;
    rchk(ADDR_PEND_LO, 8'h02);
    clr(0);
    rchk(ADDR_PEND_LO, 8'h00);
    $display("periph done");
  endtask

  task automatic t_trap();
    @(posedge clock);
    trapExec <= 1'h1;
    @(posedge clock);
    trapExec <= 1'h0;
    entry(VEC_TRAP, PRIO_L3);
    wr(ADDR_TOP_CTL, 8'h01);
    @(posedge clock);
    topLevelIrq <= 1'h1;
    entry(VEC_TOP, PRIO_L3);
    ret(8'hea);
    ret(8'hea);
    $display("trap done");
  endtask

  task automatic t_prio();
    wr(ADDR_PRIO0, 8'hf7);
    wr(ADDR_PRIO1, 8'h0f);
    @(posedge clock);
    lag <= 4'h6;
    periphFlag[2:0] <= 3'h7;
    repeat (20) @(posedge clock);
    rchk(ADDR_PEND_LO, 8'hc2);
    wr(ADDR_COND, 8'he2);
    entry(16'hffee, 2'h0);
    clr(1);
    repeat (20) @(posedge clock);
    rchk(ADDR_PEND_LO, 8'h82);
    `CHK(stackReq, 1'h0)
    ret(8'he2);
    entry(16'hffec, 2'h0);
    clr(2);
    ret(8'he2);
    entry(16'hfff8, 2'h1);
    clr(0);
    ret(8'he2);
    $display("priority done");
  endtask

  task automatic t_ext();
    wr(ADDR_SENSE, 8'h01);
    wr(ADDR_SEL_LO, 8'h03);
    @(posedge clock);
    lag <= 4'h0;
    extPins[1] <= 1'h1;
    entry(16'hfff6, PRIO_L3);
    rchk(ADDR_PEND_LO, 8'h00);
    ret(8'he2);
    $display("external done");
  endtask

  task automatic t_halt();
    wr(ADDR_PRIO0, 8'hd7);
    wr(ADDR_SENSE, 8'h00);
    @(posedge clock);
    enterHalt <= 1'h1;
    @(posedge clock);
    enterHalt <= 1'h0;
    periphFlag[3] <= 1'h1;
    repeat (10) @(posedge clock);
    #1;
    `CHK({lowPower, haltMode, condCodeReg[5], condCodeReg[3]}, 4'he)
    rchk(ADDR_PEND_HI, 8'h01);
    rchk(ADDR_MODE, 8'h07);
    @(posedge clock);
    extPins[1] <= 1'h0;
    waitw();
    entry(16'hfff6, 2'h1);
    entry(16'hffea, PRIO_L3);
    clr(3);
    ret(8'hca);
    ret(8'he2);
    $display("halt done");
  endtask

  task automatic t_wait();
    @(posedge clock);
    enterWait <= 1'h1;
    @(posedge clock);
    enterWait <= 1'h0;
    periphFlag[3] <= 1'h1;
    waitw();
    entry(16'hffea, PRIO_L3);
    clr(3);
    ret(8'he2);
    $display("wait done");
  endtask

  initial begin
    {resetn, regWr, regRd, topLevelIrq, trapExec, returnFromIsr} = '0;
    {enterWait, enterHalt, run} = '0;
    {regAddr, regWData, popCond, lag} = '0;
    {extPins, periphFlag, periphEn, periphClr} = '0;
    repeat (5) @(posedge clock);
    resetn <= 1'h1;
    @(posedge clock);
    #1;
    `CHK(vectorLoad, 1'h1)
    `CHK(vectorAddr, VEC_RESET)
    `CHK(condCodeReg, RST_COND)
    @(posedge clock);
    run <= 1'h1;
    t_regs();
    t_periph();
    t_trap();
    t_prio();
    t_ext();
    t_halt();
    t_wait();
    completeRun();
  end
endmodule
